// *** design/pmrc_pkg.sv ***
// Package for the power mode protect and run control block
package pmrc_pkg;
	// ---------------------------------------------------------------
	// Register map and field layout
	// ---------------------------------------------------------------
	localparam logic [1:0] PMRC_ADDR_PROT = 2'h0;
	localparam logic [1:0] PMRC_ADDR_CTRL = 2'h1;
	localparam logic [7:0] PMRC_PROT_MASK = 8'h2A;
	localparam logic [7:0] PMRC_CTRL_MASK = 8'h6F;
	localparam int         PMRC_BIT_ALLOW_VLP   = 5;
	localparam int         PMRC_BIT_ALLOW_LEAK  = 3;
	localparam int         PMRC_BIT_ALLOW_VLEAK = 1;
	localparam int         PMRC_RSEL_HI         = 6;
	localparam int         PMRC_RSEL_LO         = 5;
	localparam int         PMRC_BIT_ABORTED     = 3;
	localparam int         PMRC_SSEL_HI         = 2;
	localparam int         PMRC_SSEL_LO         = 0;
	localparam logic [7:0] PMRC_RESET_VAL = 8'h00;
	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] PMRC_RUN_NORMAL = 2'h0;
	localparam logic [1:0] PMRC_RUN_VLP    = 2'h2;
	localparam logic [2:0] PMRC_STOP_NORM  = 3'h0;
	localparam logic [2:0] PMRC_STOP_VLP   = 3'h2;
	localparam logic [2:0] PMRC_STOP_LEAK  = 3'h3;
	localparam logic [2:0] PMRC_STOP_VLEAK = 3'h4;
	// Status codes of the run mode state
	typedef enum logic [1:0] {
		PMRC_ST_RUN    = 2'b00,
		PMRC_ST_TO_VLP = 2'b01,
		PMRC_ST_LP_RUN = 2'b10,
		PMRC_ST_TO_RUN = 2'b11
	} pmrc_state_t;
	localparam int PMRC_SETTLE_NS = 20;
	localparam int PMRC_CLK_NS    = 5;
endpackage

// *** design/pmrc_ctrl.sv ***
// Power mode protection and run control register block
//
// Functional notes
// - Protection register writable once per reset
// - Disallowed or reserved mode: no transition
// - VLP blocked keeps run select at 00
// - Protection reset by chip reset class
// - Control reset only by power-on class
// - Reserved bits read zero, ignore writes
// - Bit 5 allows all very-low-power modes
// - Bit 3 allows low-leakage stop
// - Bit 1 allows very-low-leakage stop
// - Run select write starts run mode entry
// - Run select write blocked without permission
// - Run select cleared on exit to run
// - Run encodings 00, 10; others reserved
// - Stop-aborted flag reports previous stop entry
// - Flag cleared at stop start, set on abort
// - Stop select field at bits 2:0
// - Stop encodings 000,010,011,100; others reserved
// - User-mode writes blocked with bus error
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module pmrc_ctrl
	import pmrc_pkg::*;
#(
	parameter int SETTLE_CYC = (pmrc_pkg::PMRC_SETTLE_NS
		+ pmrc_pkg::PMRC_CLK_NS - 1) / pmrc_pkg::PMRC_CLK_NS
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        chip_rst_req,
	input  wire logic        por_rst_req,
	input  wire logic [1:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	input  wire logic        supervisor,
	input  wire logic        stop_entry_start,
	input  wire logic        stop_entry_abort,
	input  wire logic        exit_to_run,
	output logic      [7:0]  rdata,
	output logic             bus_error,
	output logic      [1:0]  mode_status,
	output logic      [2:0]  stop_mode_select,
	output logic             stop_permit
);
	import pmrc_pkg::*;

	// Settle counter is eight bits; zero would wrap and stretch a transition to 256 cycles
	if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_settle
		$error("SETTLE_CYC out of range");
	end

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic        written_q, written_d;
	logic        allow_very_low_power_q, allow_very_low_power_d;
	logic        allow_low_leak_stop_q, allow_low_leak_stop_d;
	logic        allow_very_low_leak_stop_q, allow_very_low_leak_stop_d;
	logic [1:0]  run_mode_select_q, run_mode_select_d;
	logic        stop_aborted_flag_q, stop_aborted_flag_d;
	logic [2:0]  stop_mode_select_q, stop_mode_select_d;
	pmrc_state_t st_q, st_d;
	logic [7:0]  cnt_q, cnt_d;
	logic [7:0]  rdata_d;
	logic        berr_d, permit_d;
	logic [1:0]  stat_d;
	logic        wr_ok, wr_prot, wr_ctrl, stop_ok;
	logic [1:0]  w_run_sel;
	logic [2:0]  w_stop_sel;

	// ---------------------------------------------------------------
	// Protection register next state
	// ---------------------------------------------------------------
	// Only supervisor writes land; user writes flag an error
	always_comb begin
		wr_ok   = wr && supervisor;
		wr_prot = wr_ok && addr == PMRC_ADDR_PROT;
		wr_ctrl = wr_ok && addr == PMRC_ADDR_CTRL;
		written_d                  = written_q;
		allow_very_low_power_d     = allow_very_low_power_q;
		allow_low_leak_stop_d      = allow_low_leak_stop_q;
		allow_very_low_leak_stop_d = allow_very_low_leak_stop_q;
		if (wr_prot && !written_q) begin
			written_d = 1'b1;
			allow_very_low_power_d     = wdata[PMRC_BIT_ALLOW_VLP];
			allow_low_leak_stop_d      = wdata[PMRC_BIT_ALLOW_LEAK];
			allow_very_low_leak_stop_d = wdata[PMRC_BIT_ALLOW_VLEAK];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			written_q                  <= 1'b0;
			allow_very_low_power_q     <= 1'b0;
			allow_low_leak_stop_q      <= 1'b0;
			allow_very_low_leak_stop_q <= 1'b0;
		end else if (chip_rst_req || por_rst_req) begin
			written_q                  <= 1'b0;
			allow_very_low_power_q     <= 1'b0;
			allow_low_leak_stop_q      <= 1'b0;
			allow_very_low_leak_stop_q <= 1'b0;
		end else begin
			written_q                  <= written_d;
			allow_very_low_power_q     <= allow_very_low_power_d;
			allow_low_leak_stop_q      <= allow_low_leak_stop_d;
			allow_very_low_leak_stop_q <= allow_very_low_leak_stop_d;
		end
	end

	// ---------------------------------------------------------------
	// Control register and run mode sequencer
	// ---------------------------------------------------------------
	// Permission checked against the request as written, not later
	always_comb begin
		w_run_sel           = wdata[PMRC_RSEL_HI:PMRC_RSEL_LO];
		w_stop_sel          = wdata[PMRC_SSEL_HI:PMRC_SSEL_LO];
		run_mode_select_d   = run_mode_select_q;
		stop_mode_select_d  = stop_mode_select_q;
		stop_aborted_flag_d = stop_aborted_flag_q;
		st_d                = st_q;
		cnt_d               = cnt_q;
		case (w_stop_sel)
			PMRC_STOP_NORM:  stop_ok = 1'b1;
			PMRC_STOP_VLP:   stop_ok = allow_very_low_power_q;
			PMRC_STOP_LEAK:  stop_ok = allow_low_leak_stop_q;
			PMRC_STOP_VLEAK: stop_ok = allow_very_low_leak_stop_q;
			default:         stop_ok = 1'b0;
		endcase
		if (wr_ctrl && stop_ok)
			stop_mode_select_d = w_stop_sel;
		if (wr_ctrl && w_run_sel != run_mode_select_q) begin
			if (w_run_sel == PMRC_RUN_VLP && allow_very_low_power_q
					&& st_q == PMRC_ST_RUN) begin
				run_mode_select_d = PMRC_RUN_VLP;
				st_d              = PMRC_ST_TO_VLP;
				cnt_d             = 8'(SETTLE_CYC);
			end else if (w_run_sel == PMRC_RUN_NORMAL
					&& st_q == PMRC_ST_LP_RUN) begin
				run_mode_select_d = PMRC_RUN_NORMAL;
				st_d              = PMRC_ST_TO_RUN;
				cnt_d             = 8'(SETTLE_CYC);
			end
			// other requests leave mode as is
		end
		case (st_q)
			PMRC_ST_TO_VLP: begin
				cnt_d = cnt_q - 8'h01;
				if (cnt_q == 8'h01)
					st_d = PMRC_ST_LP_RUN;
			end
			PMRC_ST_TO_RUN: begin
				cnt_d = cnt_q - 8'h01;
				if (cnt_q == 8'h01)
					st_d = PMRC_ST_RUN;
			end
			PMRC_ST_RUN, PMRC_ST_LP_RUN: ;
			default: st_d = PMRC_ST_RUN;
		endcase
		if (exit_to_run) begin
			run_mode_select_d = PMRC_RUN_NORMAL;
			st_d              = PMRC_ST_RUN;
			cnt_d             = 8'h00;
		end
		if (stop_entry_start)
			stop_aborted_flag_d = 1'b0;
		if (stop_entry_abort)
			stop_aborted_flag_d = 1'b1;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			run_mode_select_q   <= PMRC_RUN_NORMAL;
			stop_mode_select_q  <= PMRC_STOP_NORM;
			stop_aborted_flag_q <= 1'b0;
			st_q                <= PMRC_ST_RUN;
			cnt_q               <= 8'h00;
		end else if (por_rst_req) begin
			run_mode_select_q   <= PMRC_RUN_NORMAL;
			stop_mode_select_q  <= PMRC_STOP_NORM;
			stop_aborted_flag_q <= 1'b0;
			st_q                <= PMRC_ST_RUN;
			cnt_q               <= 8'h00;
		end else begin
			run_mode_select_q   <= run_mode_select_d;
			stop_mode_select_q  <= stop_mode_select_d;
			stop_aborted_flag_q <= stop_aborted_flag_d;
			st_q                <= st_d;
			cnt_q               <= cnt_d;
		end
	end

	// ---------------------------------------------------------------
	// Read path and outputs
	// ---------------------------------------------------------------
	// Reserved bits are masked so they always read zero
	always_comb begin
		rdata_d = PMRC_RESET_VAL;
		if (rd && addr == PMRC_ADDR_PROT) begin
			rdata_d[PMRC_BIT_ALLOW_VLP]   = allow_very_low_power_q;
			rdata_d[PMRC_BIT_ALLOW_LEAK]  = allow_low_leak_stop_q;
			rdata_d[PMRC_BIT_ALLOW_VLEAK] = allow_very_low_leak_stop_q;
			rdata_d = rdata_d & PMRC_PROT_MASK;
		end else if (rd && addr == PMRC_ADDR_CTRL) begin
			rdata_d[PMRC_RSEL_HI:PMRC_RSEL_LO] = run_mode_select_q;
			rdata_d[PMRC_BIT_ABORTED]          = stop_aborted_flag_q;
			rdata_d[PMRC_SSEL_HI:PMRC_SSEL_LO] = stop_mode_select_q;
			rdata_d = rdata_d & PMRC_CTRL_MASK;
		end
		berr_d   = wr && !supervisor;
		stat_d   = (st_q == PMRC_ST_LP_RUN || st_q == PMRC_ST_TO_RUN)
			? PMRC_RUN_VLP : PMRC_RUN_NORMAL;
		case (stop_mode_select_q)
			PMRC_STOP_NORM:  permit_d = 1'b1;
			PMRC_STOP_VLP:   permit_d = allow_very_low_power_q;
			PMRC_STOP_LEAK:  permit_d = allow_low_leak_stop_q;
			PMRC_STOP_VLEAK: permit_d = allow_very_low_leak_stop_q;
			default:         permit_d = 1'b0;
		endcase
	end

	// Output registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata            <= 8'h00;
			bus_error        <= 1'b0;
			mode_status      <= PMRC_RUN_NORMAL;
			stop_mode_select <= PMRC_STOP_NORM;
			stop_permit      <= 1'b1;
		end else begin
			rdata            <= rdata_d;
			bus_error        <= berr_d;
			mode_status      <= stat_d;
			stop_mode_select <= stop_mode_select_q;
			stop_permit      <= permit_d;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_once;
		@(posedge clk) disable iff (!resetn)
		written_q && wr_prot && !chip_rst_req && !por_rst_req
			|=> $stable(allow_very_low_power_q)
			&& $stable(allow_low_leak_stop_q)
			&& $stable(allow_very_low_leak_stop_q);
	endproperty
	a_once: assert property (p_once)
		else $error("protection changed after first write");

	property p_vlp_block;
		@(posedge clk) disable iff (!resetn)
		wr_ctrl && !allow_very_low_power_q && st_q == PMRC_ST_RUN
			&& !exit_to_run && !por_rst_req
			|=> run_mode_select_q == PMRC_RUN_NORMAL;
	endproperty
	a_vlp_block: assert property (p_vlp_block)
		else $error("blocked VLP request changed run select");

	// Mask chosen by the register that was read
	property p_reserved;
		@(posedge clk) disable iff (!resetn)
		$past(rd) |-> (rdata & ~(($past(addr) == PMRC_ADDR_PROT)
			? PMRC_PROT_MASK : PMRC_CTRL_MASK)) == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bit read nonzero");

	property p_exit;
		@(posedge clk) disable iff (!resetn)
		exit_to_run && !por_rst_req
			|=> run_mode_select_q == PMRC_RUN_NORMAL;
	endproperty
	a_exit: assert property (p_exit)
		else $error("run select not cleared on exit");

	property p_stop_aborted_flag;
		@(posedge clk) disable iff (!resetn)
		stop_entry_abort && !por_rst_req |=> stop_aborted_flag_q;
	endproperty
	a_stop_aborted_flag: assert property (p_stop_aborted_flag)
		else $error("abort flag not set");

	property p_stop_aborted_flag_clr;
		@(posedge clk) disable iff (!resetn)
		stop_entry_start && !stop_entry_abort |=> !stop_aborted_flag_q;
	endproperty
	a_stop_aborted_flag_clr: assert property (p_stop_aborted_flag_clr)
		else $error("abort flag not cleared at entry");

	// Hardware exit may move the run select in the same cycle
	property p_user;
		@(posedge clk) disable iff (!resetn)
		wr && !supervisor && !chip_rst_req && !por_rst_req
			&& !exit_to_run
			|=> bus_error && $stable(run_mode_select_q)
			&& $stable(written_q);
	endproperty
	a_user: assert property (p_user)
		else $error("user write not blocked");

	property p_status;
		@(posedge clk) disable iff (!resetn)
		st_q == PMRC_ST_RUN && $past(st_q) == PMRC_ST_RUN
			&& $past(st_q, 2) == PMRC_ST_RUN
			|-> mode_status == PMRC_RUN_NORMAL;
	endproperty
	a_status: assert property (p_status)
		else $error("status not normal run");

	property p_bad_stop;
		@(posedge clk) disable iff (!resetn)
		wr_ctrl && !stop_ok && !por_rst_req
			|=> $stable(stop_mode_select_q);
	endproperty
	a_bad_stop: assert property (p_bad_stop)
		else $error("reserved stop select accepted");

	property p_run_rsvd;
		@(posedge clk) disable iff (!resetn)
		wr_ctrl && w_run_sel != PMRC_RUN_NORMAL
			&& w_run_sel != PMRC_RUN_VLP && !exit_to_run
			&& !por_rst_req |=> $stable(run_mode_select_q);
	endproperty
	a_run_rsvd: assert property (p_run_rsvd)
		else $error("reserved run select accepted");

	// Status must not run ahead of the settling transition
	property p_early_stat;
		@(posedge clk) disable iff (!resetn)
		st_q == PMRC_ST_TO_VLP |-> mode_status == PMRC_RUN_NORMAL;
	endproperty
	a_early_stat: assert property (p_early_stat)
		else $error("status moved before transition ended");

	c_vlp: cover property (@(posedge clk) disable iff (!resetn)
		st_q == PMRC_ST_TO_VLP ##[1:20] st_q == PMRC_ST_LP_RUN);
	c_back: cover property (@(posedge clk) disable iff (!resetn)
		st_q == PMRC_ST_TO_RUN ##[1:20] st_q == PMRC_ST_RUN);
	c_abort: cover property (@(posedge clk) disable iff (!resetn)
		stop_entry_start ##[1:10] stop_entry_abort);
	c_blocked: cover property (@(posedge clk) disable iff (!resetn)
		wr_ctrl && !allow_very_low_power_q && w_run_sel == PMRC_RUN_VLP);
endmodule // pmrc_ctrl

// *** dv/pmrc_ctrl_tb.sv ***
// Self-checking bench for the power mode protect and run control block
`timescale 1ns/10ps
module pmrc_ctrl_tb;
	import pmrc_pkg::*;
	// Settle count kept at the design default
	localparam int SC = 4;
	logic       clk, resetn, wr, rd, supervisor, bus_error, stop_permit;
	logic       stop_entry_start, stop_entry_abort, exit_to_run;
	logic       chip_rst_req, por_rst_req, berr, sa;
	logic [1:0] addr, mode_status;
	logic [7:0] wdata, rdata, v, p, w;
	logic [2:0] stop_mode_select, sm;
	logic [4:0] m;
	int         n_mismatch, compares, cyc;

	pmrc_ctrl #(.SETTLE_CYC(SC)) dut (.clk(clk), .resetn(resetn),
		.chip_rst_req(chip_rst_req), .por_rst_req(por_rst_req),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.supervisor(supervisor), .stop_entry_start(stop_entry_start),
		.stop_entry_abort(stop_entry_abort), .exit_to_run(exit_to_run),
		.rdata(rdata), .bus_error(bus_error), .mode_status(mode_status),
		.stop_mode_select(stop_mode_select), .stop_permit(stop_permit));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	// Hang guard, far above the roughly two hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic wreg(input logic [1:0] a, input logic [7:0] d,
		input logic s);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		supervisor <= s;
		@(posedge clk);
		wr <= 1'b0;
		supervisor <= 1'b1;
		#1 berr = bus_error;
	endtask

	// Read data exist only in the cycle after the strobe
	task automatic rreg(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// Mask order: start, abort, exit, chip reset, power-on reset
	task automatic pulse(input logic [4:0] k);
		@(posedge clk);
		{stop_entry_start, stop_entry_abort, exit_to_run, chip_rst_req,
			por_rst_req} <= k;
		@(posedge clk);
		{stop_entry_start, stop_entry_abort, exit_to_run, chip_rst_req,
			por_rst_req} <= 5'h00;
		#1;
	endtask

	function automatic logic ok_stop(input logic [2:0] s,
		input logic [7:0] pr);
		case (s)
			3'h0: return 1'b1;
			3'h2: return pr[5];
			3'h3: return pr[3];
			3'h4: return pr[1];
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] ctrl_exp(input logic [1:0] rm);
		return {1'b0, rm, 1'b0, sa, sm};
	endfunction

	task automatic conclude();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		{stop_entry_start, stop_entry_abort, exit_to_run, chip_rst_req,
			por_rst_req} = 5'h00;
		{addr, wdata, wr, rd, sa, sm} = '0;
		supervisor = 1'b1;
		{n_mismatch, compares, cyc} = '0;
		void'($urandom(6));
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		// Reset values, unmapped places read zero
		for (int a = 0; a < 4; a++) begin
			rreg(2'(a), v);
			chk(v, 8'h00);
		end
		wreg(2'h0, 8'hFF, 1'b0);
		chk({7'h0, berr}, 8'h01);
		wreg(2'h1, 8'h40, 1'b1);
		rreg(2'h1, v);
		chk(v, 8'h00);
		chk({6'h0, mode_status}, 8'h00);
		p = 8'($urandom) | 8'h20;
		wreg(2'h0, p, 1'b1);
		chk({7'h0, berr}, 8'h00);
		wreg(2'h0, ~p, 1'b1);
		rreg(2'h0, v);
		chk(v, p & 8'h2A);
		// random stop selects, run select 00 or reserved 01
		for (int i = 0; i < 24; i++) begin
			w = 8'($urandom) & 8'hBF;
			if (ok_stop(w[2:0], p))
				sm = w[2:0];
			wreg(2'h1, w, 1'b1);
			rreg(2'h1, v);
			chk(v, ctrl_exp(2'h0));
			chk({5'h0, stop_mode_select}, {5'h0, sm});
			chk({7'h0, stop_permit}, 8'h01);
		end
		// abort, start, then both at once
		for (int i = 1; i < 4; i++) begin
			m = 5'(i * 8);
			pulse(m);
			sa = m[3];
			rreg(2'h1, v);
			chk(v, ctrl_exp(2'h0));
		end
		// low-power run asked for only from normal run
		wreg(2'h1, 8'h40 | {5'h0, sm}, 1'b1);
		chk({6'h0, mode_status}, 8'h00);
		rreg(2'h1, v);
		chk(v, ctrl_exp(2'h2));
		repeat (SC + 2) @(posedge clk);
		#1 chk({6'h0, mode_status}, 8'h02);
		wreg(2'h1, 8'h60 | {5'h0, sm}, 1'b1);
		rreg(2'h1, v);
		chk(v, ctrl_exp(2'h2));
		chk({6'h0, mode_status}, 8'h02);
		// normal run asked for only once status shows low power
		wreg(2'h1, {5'h0, sm}, 1'b1);
		repeat (SC + 2) @(posedge clk);
		#1 chk({6'h0, mode_status}, 8'h00);
		rreg(2'h1, v);
		chk(v, ctrl_exp(2'h0));
		wreg(2'h1, 8'h40 | {5'h0, sm}, 1'b1);
		repeat (SC + 2) @(posedge clk);
		pulse(5'h04);
		rreg(2'h1, v);
		chk(v, ctrl_exp(2'h0));
		chk({6'h0, mode_status}, 8'h00);
		pulse(5'h02);
		rreg(2'h0, v);
		chk(v, 8'h00);
		rreg(2'h1, v);
		chk(v, ctrl_exp(2'h0));
		wreg(2'h0, 8'h08, 1'b1);
		wreg(2'h0, 8'h22, 1'b1);
		rreg(2'h0, v);
		chk(v, 8'h08);
		sm = 3'h3;
		wreg(2'h1, 8'h03, 1'b1);
		wreg(2'h1, 8'h02, 1'b1);
		rreg(2'h1, v);
		chk(v, ctrl_exp(2'h0));
		// Stop select survives, but its permission is gone
		pulse(5'h02);
		@(posedge clk);
		#1 chk({7'h0, stop_permit}, 8'h00);
		pulse(5'h01);
		sa = 1'b0;
		sm = 3'h0;
		rreg(2'h1, v);
		chk(v, ctrl_exp(2'h0));
		conclude();
	end
endmodule // pmrc_ctrl_tb
